// ---- src/oneshot_timer.sv ----
// Purpose: Four 8-bit timer channels in two cascadable one-shot units.
// Assumes: Byte register port, read data one cycle after the strobe.
// Notes: Channel c register block at c*16; global registers at 0x40.
`timescale 1ns/100ps
`include "oneshot_timer_map.svh"

// Summary of operation
// RL1: Channels zero and one form unit zero; two and three form unit one.
// RL2: Channels count in 8 bits; a cascaded unit counts in 16 bits.
// RL3: Counter, compare A and compare B each write without touching others.
// RL4: Stop gates the counter clock and holds the count; start resumes.
// RL5: A one-shot drives its pin high, low or not at all throughout.
// RL6: A cascaded unit one shows its waveform on channel two's pin.
// RL7: One transfer request at one-shot end when enabled, none otherwise.
// RL8: Compare match B flag sets when the one-shot delay completes.
// RL9: The one-shot timer stops itself at the end of its period.
// RL10: An enabled interrupt is raised at the end of the one-shot period.
// RL11: Software rounds periods up to whole ticks.
// RL12: Software rounds pulse widths down to whole ticks.
// RL13: Shutting a unit down stops both channels for low power.
// RL14: Each compare sets, clears, toggles or keeps the output pin.
// RL15: The counter clears after match A, after match B, or never.
// RL16: The counter steps once per enabled tick; equality is a match.
// RL17: A cascaded upper channel counts once per lower channel wrap.
module oneshot_timer
  import oneshot_timer_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  output logic [3:0] timer_output_pin,
  output logic [3:0] timer_output_pin_oe,
  output logic [3:0] transfer_controller_request,
  output logic irq
);

  logic [3:0][7:0] match_a_limit;
  logic [3:0][7:0] match_b_limit;
  logic [3:0][7:0] chan_ctrl;
  logic [3:0][7:0] chan_out;
  logic [3:0][2:0] chan_status;
  logic [3:0][2:0] chan_mask;
  logic [7:0] unit_ctrl;
  logic [3:0] irq_enable;
  logic [3:0][7:0] count_value;
  logic [3:0] hit_a;
  logic [3:0] hit_b;
  logic [3:0] ovf;
  logic [3:0] done;
  logic [3:0] level;
  logic [3:0] oe;
  logic [3:0] chan_wr;
  logic glob_sel;
  logic [3:0] reg_sel;
  logic [1:0] chan_idx;
  logic [7:0] next_rdata;

  unit_link_if link0 ();
  unit_link_if link1 ();

  assign chan_idx = addr[5:4];
  assign reg_sel = addr[3:0];
  assign glob_sel = addr[7:6] == 2'b01;

  // ----------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------
  for (genvar c = 0; c < 4; c++) begin : g_dec
    assign chan_wr[c] = wr && addr[7:6] == 2'b00 && chan_idx == c;
  end

  // ----------------------------------------------------------------
  // Channel registers
  // ----------------------------------------------------------------
  for (genvar c = 0; c < 4; c++) begin : g_regs
    always_ff @(posedge clk_sys) begin
      if (reset) begin
        match_a_limit[c] <= `LIMIT_RESET;
        match_b_limit[c] <= `LIMIT_RESET;
        chan_out[c] <= `CTRL_RESET;
        chan_mask[c] <= 3'h0;
      end else if (chan_wr[c]) begin
        case (reg_sel)
          `MATCH_A_LIMIT_OFS: match_a_limit[c] <= wdata; // RL3
          `MATCH_B_LIMIT_OFS: match_b_limit[c] <= wdata; // RL3
          `CHAN_OUT_OFS: chan_out[c] <= wdata;
          `CHAN_MASK_OFS: chan_mask[c] <= wdata[2:0];
          default: ;
        endcase
      end
    end

    // Run bit falls by itself when the one-shot completes
    always_ff @(posedge clk_sys) begin
      if (reset) begin
        chan_ctrl[c] <= `CTRL_RESET;
      end else if (chan_wr[c] && reg_sel == `CHAN_CTRL_OFS) begin
        chan_ctrl[c] <= wdata; // RL4
      end else if (done[c]) begin
        chan_ctrl[c][`CTRL_RUN_BIT] <= 1'b0; // RL9
      end
    end

    // Sticky events; set wins over write-one-to-clear
    always_ff @(posedge clk_sys) begin
      if (reset) begin
        chan_status[c] <= 3'h0;
      end else begin
        chan_status[c] <= (chan_status[c] & ~((chan_wr[c]
          && reg_sel == `CHAN_STATUS_OFS) ? wdata[2:0] : 3'h0))
          | {ovf[c], hit_b[c], hit_a[c]}; // RL8
      end
    end

    // One-cycle request at one-shot end
    always_ff @(posedge clk_sys) begin
      if (reset) begin
        transfer_controller_request[c] <= 1'b0;
      end else begin
        transfer_controller_request[c] <= done[c]
          && chan_ctrl[c][`CTRL_XFER_EN_BIT]; // RL7
      end
    end
  end

  // ----------------------------------------------------------------
  // Global registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      unit_ctrl <= `CTRL_RESET;
      irq_enable <= 4'h0;
    end else if (wr && glob_sel) begin
      if (addr == `UNIT_CTRL_ADDR) begin
        unit_ctrl <= wdata; // RL13
      end
      if (addr == `IRQ_ENABLE_ADDR) begin
        irq_enable <= wdata[3:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= 1'b0;
      for (int c = 0; c < 4; c++) begin
        if (irq_enable[c] && |(chan_status[c] & chan_mask[c])) begin
          irq <= 1'b1; // RL10
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always_comb begin
    next_rdata = 8'h00;
    if (addr[7:6] == 2'b00) begin
      case (reg_sel)
        `COUNT_VALUE_OFS: next_rdata = count_value[chan_idx];
        `MATCH_A_LIMIT_OFS: next_rdata = match_a_limit[chan_idx];
        `MATCH_B_LIMIT_OFS: next_rdata = match_b_limit[chan_idx];
        `CHAN_CTRL_OFS: next_rdata = chan_ctrl[chan_idx];
        `CHAN_OUT_OFS: next_rdata = chan_out[chan_idx];
        `CHAN_STATUS_OFS: next_rdata = {5'h00, chan_status[chan_idx]};
        `CHAN_MASK_OFS: next_rdata = {5'h00, chan_mask[chan_idx]};
        default: next_rdata = 8'h00;
      endcase
    end else if (addr == `UNIT_CTRL_ADDR) begin
      next_rdata = unit_ctrl;
    end else if (addr == `IRQ_ENABLE_ADDR) begin
      next_rdata = {4'h0, irq_enable};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rdata <= 8'h00;
    end else if (rd) begin
      rdata <= next_rdata;
    end else begin
      rdata <= 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Unit hookup: upper channel index 0, lower index 1
  // ----------------------------------------------------------------
  always_comb begin
    link0.cascade = unit_ctrl[`UNIT_CASCADE_LSB]; // RL1
    link1.cascade = unit_ctrl[`UNIT_CASCADE_LSB + 1];
    link0.shutdown = unit_ctrl[`UNIT_SHUTDOWN_LSB]; // RL13
    link1.shutdown = unit_ctrl[`UNIT_SHUTDOWN_LSB + 1];
    link0.cnt_wdata = wdata;
    link1.cnt_wdata = wdata;
    for (int k = 0; k < 2; k++) begin
      link0.run[k] = chan_ctrl[k][`CTRL_RUN_BIT];
      link1.run[k] = chan_ctrl[k + 2][`CTRL_RUN_BIT];
      link0.oneshot[k] = chan_ctrl[k][`CTRL_ONESHOT_BIT];
      link1.oneshot[k] = chan_ctrl[k + 2][`CTRL_ONESHOT_BIT];
      link0.clr_mode[k] = chan_ctrl[k][`CTRL_CLR_LSB +: 2];
      link1.clr_mode[k] = chan_ctrl[k + 2][`CTRL_CLR_LSB +: 2];
      link0.act_a[k] = chan_out[k][`CTRL_ACTION_A_LSB +: 2];
      link1.act_a[k] = chan_out[k + 2][`CTRL_ACTION_A_LSB +: 2];
      link0.act_b[k] = chan_out[k][`CTRL_ACTION_B_LSB +: 2];
      link1.act_b[k] = chan_out[k + 2][`CTRL_ACTION_B_LSB +: 2];
      link0.shot[k] = chan_out[k][`CTRL_SHOT_LSB +: 2];
      link1.shot[k] = chan_out[k + 2][`CTRL_SHOT_LSB +: 2];
      link0.limit_a[k] = match_a_limit[k];
      link1.limit_a[k] = match_a_limit[k + 2];
      link0.limit_b[k] = match_b_limit[k];
      link1.limit_b[k] = match_b_limit[k + 2];
      link0.cnt_wr[k] = chan_wr[k] && reg_sel == `COUNT_VALUE_OFS; // RL3
      link1.cnt_wr[k] = chan_wr[k + 2] && reg_sel == `COUNT_VALUE_OFS;
    end
  end

  assign count_value = {link1.count, link0.count};
  assign hit_a = {link1.hit_a, link0.hit_a};
  assign hit_b = {link1.hit_b, link0.hit_b};
  assign ovf = {link1.ovf, link0.ovf};
  assign done = {link1.done, link0.done};
  assign level = {link1.pin_level, link0.pin_level};
  assign oe = {link1.pin_oe, link0.pin_oe};

  // Cascaded unit one leaves on channel two's pin
  always_comb begin
    timer_output_pin = level;
    timer_output_pin_oe = oe;
    if (link0.cascade) begin
      timer_output_pin[0] = level[1];
    end
    if (link1.cascade) begin
      timer_output_pin[2] = level[3]; // RL6
    end
  end

  timer_pair unit0 (
    .clk_sys(clk_sys),
    .reset(reset),
    .link(link0.unit)
  );

  timer_pair unit1 (
    .clk_sys(clk_sys),
    .reset(reset),
    .link(link1.unit)
  );

endmodule : oneshot_timer

// ---- src/oneshot_timer_map.svh ----
// Purpose: Register offsets, field positions and reset values of the timer.
// Assumes: Byte-wide register port, 8-bit addresses.
// Notes: Definitions only.
`ifndef ONESHOT_TIMER_MAP_SVH
`define ONESHOT_TIMER_MAP_SVH

// Per-channel register block: channel index in addr[5:4], register in [3:0]
`define COUNT_VALUE_OFS 4'h0
`define MATCH_A_LIMIT_OFS 4'h1
`define MATCH_B_LIMIT_OFS 4'h2
`define CHAN_CTRL_OFS 4'h3
`define CHAN_OUT_OFS 4'h4
`define CHAN_STATUS_OFS 4'h5
`define CHAN_MASK_OFS 4'h6
// Global registers at addr[7:6] = 1
`define UNIT_CTRL_ADDR 8'h40
`define IRQ_ENABLE_ADDR 8'h41

// Channel control fields
`define CTRL_RUN_BIT 0
`define CTRL_ONESHOT_BIT 1
`define CTRL_CLR_LSB 2
`define CTRL_XFER_EN_BIT 4
`define CTRL_ACTION_A_LSB 0
`define CTRL_ACTION_B_LSB 2
`define CTRL_SHOT_LSB 4
// Unit control fields
`define UNIT_CASCADE_LSB 0
`define UNIT_SHUTDOWN_LSB 2

// Status fields
`define STAT_MATCH_A_BIT 0
`define STAT_MATCH_B_BIT 1
`define STAT_OVF_BIT 2

`define CTRL_RESET 8'h00
`define LIMIT_RESET 8'hFF
`define COUNT_RESET 8'h00

`endif

// ---- src/oneshot_timer_pkg.sv ----
// Purpose: Types shared by the timer modules.
// Assumes: Nothing.
// Notes: Offsets and fields live in the map header.
package oneshot_timer_pkg;

  typedef enum logic [1:0] {
    CLR_NONE = 2'b00,
    CLR_ON_A = 2'b01,
    CLR_ON_B = 2'b10
  } clear_mode_t;

  typedef enum logic [1:0] {
    ACT_KEEP = 2'b00,
    ACT_LOW = 2'b01,
    ACT_HIGH = 2'b10,
    ACT_TOGGLE = 2'b11
  } pin_action_t;

  typedef enum logic [1:0] {
    SHOT_OFF = 2'b00,
    SHOT_LOW = 2'b01,
    SHOT_HIGH = 2'b10
  } shot_level_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01,
    ST_SHOT = 2'b10
  } run_state_t;

endpackage : oneshot_timer_pkg

// ---- src/unit_link_if.sv ----
// Purpose: Signals between the register file and one two-channel unit.
// Assumes: One clock domain.
// Notes: Upper channel is index 0 of the pair, lower is index 1.
`timescale 1ns/100ps
interface unit_link_if;
  logic cascade;
  logic shutdown;
  logic [1:0] run;
  logic [1:0] oneshot;
  logic [1:0][1:0] clr_mode;
  logic [1:0][1:0] act_a;
  logic [1:0][1:0] act_b;
  logic [1:0][1:0] shot;
  logic [1:0][7:0] limit_a;
  logic [1:0][7:0] limit_b;
  logic [1:0] cnt_wr;
  logic [7:0] cnt_wdata;
  logic [1:0][7:0] count;
  logic [1:0] hit_a;
  logic [1:0] hit_b;
  logic [1:0] ovf;
  logic [1:0] done;
  logic [1:0] pin_level;
  logic [1:0] pin_oe;

  modport ctrl (output cascade, shutdown, run, oneshot, clr_mode, act_a,
    act_b, shot, limit_a, limit_b, cnt_wr, cnt_wdata,
    input count, hit_a, hit_b, ovf, done, pin_level, pin_oe);
  modport unit (input cascade, shutdown, run, oneshot, clr_mode, act_a,
    act_b, shot, limit_a, limit_b, cnt_wr, cnt_wdata,
    output count, hit_a, hit_b, ovf, done, pin_level, pin_oe);
endinterface : unit_link_if

// ---- src/timer_pair.sv ----
// Purpose: Two 8-bit channels that may be joined into one 16-bit timer.
// Assumes: Counting on every clk_sys edge while running.
// Notes: In cascade the pair's waveform leaves on the upper channel pin.
`timescale 1ns/100ps
`include "oneshot_timer_map.svh"
module timer_pair
  import oneshot_timer_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  unit_link_if.unit link
);

  logic [15:0] wide_count;
  logic [15:0] wide_a;
  logic [15:0] wide_b;
  logic [1:0] tick;
  logic [1:0] clr;
  logic [1:0] m_a;
  logic [1:0] m_b;
  logic [1:0][7:0] cnt;
  logic [1:0] level;

  assign wide_count = {cnt[0], cnt[1]};
  assign wide_a = {link.limit_a[0], link.limit_a[1]};
  assign wide_b = {link.limit_b[0], link.limit_b[1]};
  assign link.count = cnt;

  // ----------------------------------------------------------------
  // Tick, match and clear per channel
  // ----------------------------------------------------------------
  always_comb begin
    // Lower channel drives the pair when cascaded
    tick[1] = link.run[1] && !link.shutdown; // RL4 RL13 RL16
    if (link.cascade) begin // RL1
      m_a[1] = wide_count == wide_a; // RL2
      m_b[1] = wide_count == wide_b;
      m_a[0] = 1'b0;
      m_b[0] = 1'b0;
      tick[0] = tick[1] && cnt[1] == 8'hFF; // RL17
      clr[1] = tick[1] && ((clear_mode_t'(link.clr_mode[1]) == CLR_ON_A
        && m_a[1]) || (clear_mode_t'(link.clr_mode[1]) == CLR_ON_B
        && m_b[1])); // RL15
      clr[0] = clr[1];
    end else begin
      m_a[1] = cnt[1] == link.limit_a[1];
      m_b[1] = cnt[1] == link.limit_b[1];
      m_a[0] = cnt[0] == link.limit_a[0];
      m_b[0] = cnt[0] == link.limit_b[0];
      tick[0] = link.run[0] && !link.shutdown; // RL4 RL13
      for (int i = 0; i < 2; i++) begin
        clr[i] = tick[i] && ((clear_mode_t'(link.clr_mode[i]) == CLR_ON_A
          && m_a[i]) || (clear_mode_t'(link.clr_mode[i]) == CLR_ON_B
          && m_b[i])); // RL15
      end
    end
  end

  // ----------------------------------------------------------------
  // Counters, events and output pins
  // ----------------------------------------------------------------
  for (genvar i = 0; i < 2; i++) begin : g_chan
    // Match events report only from the channel that owns the compare; overflow from the upper in cascade
    assign link.hit_a[i] = tick[i] && m_a[i];
    assign link.hit_b[i] = tick[i] && m_b[i]; // RL8
    assign link.ovf[i] = tick[i] && cnt[i] == 8'hFF && !clr[i]
      && !(link.cascade && i == 1);
    assign link.done[i] = link.hit_b[i] && link.oneshot[i]; // RL9
    assign link.pin_level[i] = level[i];

    always_ff @(posedge clk_sys) begin
      if (reset) begin
        cnt[i] <= `COUNT_RESET;
      end else if (link.cnt_wr[i]) begin
        cnt[i] <= link.cnt_wdata; // RL3
      end else if (clr[i]) begin
        cnt[i] <= 8'h00;
      end else if (tick[i]) begin
        cnt[i] <= cnt[i] + 8'h01; // RL16
      end
    end

    always_ff @(posedge clk_sys) begin
      if (reset) begin
        level[i] <= 1'b0;
      end else if (link.oneshot[i]) begin
        // Hold the configured level while the shot runs
        level[i] <= link.run[i] && shot_level_t'(link.shot[i]) == SHOT_HIGH
          && !link.done[i]; // RL5
      end else if (link.hit_b[i]) begin
        case (pin_action_t'(link.act_b[i])) // RL14
          ACT_LOW: level[i] <= 1'b0;
          ACT_HIGH: level[i] <= 1'b1;
          ACT_TOGGLE: level[i] <= !level[i];
          default: level[i] <= level[i];
        endcase
      end else if (link.hit_a[i]) begin
        case (pin_action_t'(link.act_a[i])) // RL14
          ACT_LOW: level[i] <= 1'b0;
          ACT_HIGH: level[i] <= 1'b1;
          ACT_TOGGLE: level[i] <= !level[i];
          default: level[i] <= level[i];
        endcase
      end
    end
  end

  // Cascade: lower channel's waveform leaves on the upper pin
  always_comb begin
    link.pin_oe[1] = !link.cascade && (!link.oneshot[1]
      || shot_level_t'(link.shot[1]) != SHOT_OFF);
    link.pin_oe[0] = link.oneshot[link.cascade ? 1 : 0] ?
      shot_level_t'(link.shot[link.cascade ? 1 : 0]) != SHOT_OFF : 1'b1;
  end

endmodule : timer_pair

// ---- bench/oneshot_timer_props.sv ----
// Purpose: Port-level assertions for the one-shot timer.
// Assumes: Software reaches the block only through its register port.
// Notes: Shadows track the fields that only software writes.
`timescale 1ns/100ps
`include "oneshot_timer_map.svh"
module oneshot_timer_props (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic [3:0] timer_output_pin,
  input wire logic [3:0] timer_output_pin_oe,
  input wire logic [3:0] transfer_controller_request,
  input wire logic irq
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);

  // ----
  // Shadows
  // ----
  logic [7:0] lim [0:7];
  logic [7:0] lim_rd;
  logic [7:0] irq_en;
  logic [3:0] xfer, xfer_d, xfer_dd;
  logic [1:0] shut, shut_d, shut_dd;
  logic [3:0] req, quiet, no_xfer;
  logic is_lim;
  logic [2:0] idx;
  assign req = transfer_controller_request;
  assign is_lim = addr[7:6] == 2'b00 && (addr[3:0] == `MATCH_A_LIMIT_OFS
    || addr[3:0] == `MATCH_B_LIMIT_OFS);
  assign idx = {addr[5:4], addr[1]};
  // Two stages of delay cover an event already in flight at the write
  assign quiet = {{2{&{shut[1], shut_d[1], shut_dd[1]}}},
    {2{&{shut[0], shut_d[0], shut_dd[0]}}}};
  assign no_xfer = ~(xfer | xfer_d | xfer_dd);
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      for (int i = 0; i < 8; i++) begin
        lim[i] <= `LIMIT_RESET;
      end
    end else if (wr && is_lim) begin
      lim[idx] <= wdata;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (rd) begin
      lim_rd <= lim[idx];
    end
  end
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      irq_en <= 8'h00;
      xfer <= 4'h0;
      shut <= 2'b00;
    end else if (wr) begin
      if (addr == `IRQ_ENABLE_ADDR) irq_en <= wdata;
      if (addr == `UNIT_CTRL_ADDR) shut <= wdata[3:2];
      if (addr[7:6] == 2'b00 && addr[3:0] == `CHAN_CTRL_OFS)
        xfer[addr[5:4]] <= wdata[`CTRL_XFER_EN_BIT];
    end
  end
  always_ff @(posedge clk_sys) begin
    xfer_d <= xfer;
    xfer_dd <= xfer_d;
    shut_d <= shut;
    shut_dd <= shut_d;
  end

  // ----
  // Properties
  // ----
  sequence s_lim_read;
    rd && is_lim;
  endsequence
  property p_lim_readback;
    s_lim_read |=> rdata == lim_rd;
  endproperty
  a_lim_readback: assert property (p_lim_readback)
    else $error("limit register read back wrong");
  property p_read_idle;
    !rd |=> rdata == 8'h00;
  endproperty
  a_read_idle: assert property (p_read_idle)
    else $error("read data not zero outside a read");
  property p_reset_quiet;
    $fell(reset) |-> rdata == 8'h00 && timer_output_pin == 4'h0
      && req == 4'h0 && !irq;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet)
    else $error("outputs not quiet after reset");
  property p_req_pulse;
    |req |=> (req & $past(req)) == 4'h0;
  endproperty
  a_req_pulse: assert property (p_req_pulse)
    else $error("transfer request longer than one cycle");
  property p_irq_fall;
    $fell(irq) |-> $past(wr) || $past(wr, 2);
  endproperty
  a_irq_fall: assert property (p_irq_fall)
    else $error("interrupt dropped without a write");
  property p_irq_off;
    irq_en == 8'h00 && $past(irq_en) == 8'h00 |-> !irq;
  endproperty
  a_irq_off: assert property (p_irq_off)
    else $error("interrupt raised while disabled");
  property p_shut_quiet;
    quiet != 4'h0 |-> (req & quiet) == 4'h0;
  endproperty
  a_shut_quiet: assert property (p_shut_quiet)
    else $error("request from a shut down unit");
  property p_xfer_off;
    no_xfer != 4'h0 |-> (req & no_xfer) == 4'h0;
  endproperty
  a_xfer_off: assert property (p_xfer_off)
    else $error("request from a channel without transfer enable");
endmodule : oneshot_timer_props

bind oneshot_timer oneshot_timer_props u_props (.clk_sys(clk_sys),
  .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .timer_output_pin(timer_output_pin),
  .timer_output_pin_oe(timer_output_pin_oe),
  .transfer_controller_request(transfer_controller_request), .irq(irq));

// ---- bench/oneshot_timer_bench.sv ----
// Purpose: Self-checking bench for the one-shot timer.
// Assumes: Map header offsets; counters tick on every clk_sys.
// Notes: Each scenario task judges its own results.
`timescale 1ns/100ps
`include "oneshot_timer_map.svh"
module oneshot_timer_bench;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic [3:0] pin, oe, req;
  logic irq;
  int failures = 0;
  int n_compared = 0;

  oneshot_timer dut (.clk_sys(clk_sys), .reset(reset), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .timer_output_pin(pin), .timer_output_pin_oe(oe),
    .transfer_controller_request(req), .irq(irq));

  always #2 clk_sys = ~clk_sys;

  // ----
  // Helpers
  // ----
  task final_report;
    if (failures == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : final_report
  task check(input logic [7:0] seen, input logic [7:0] want);
    n_compared++;
    if (seen !== want) begin
      failures++;
      $display("[FAIL] %0t: saw %h, expected %h", $time, seen, want);
    end
  endtask : check
  task bit_is(input logic seen, input logic want);
    check({7'h00, seen}, {7'h00, want});
  endtask : bit_is
  task tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick
  task put(input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
    @(posedge clk_sys);
  endtask : put
  task get(input logic [7:0] a, output logic [7:0] d);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1;
    d = rdata;
    @(posedge clk_sys);
  endtask : get
  task expect_reg(input logic [7:0] a, input logic [7:0] want);
    logic [7:0] d;
    get(a, d);
    check(d, want);
  endtask : expect_reg
  task wait_req(input int c, input int bound, input logic want);
    logic seen;
    seen = 1'b0;
    for (int i = 0; i < bound && !seen; i++) begin
      tick(1);
      seen = req[c];
    end
    bit_is(seen, want);
    if (want && !seen) final_report();
  endtask : wait_req
  task changes(input int c, output int n);
    logic last;
    n = 0;
    tick(0);
    last = pin[c];
    repeat (12) begin
      tick(1);
      if (pin[c] !== last) n++;
      last = pin[c];
    end
  endtask : changes

  // ----
  // Scenarios
  // ----
  task t_reset_values;
    for (int c = 0; c < 4; c++) begin
      expect_reg({2'b00, c[1:0], `COUNT_VALUE_OFS}, `COUNT_RESET);
      expect_reg({2'b00, c[1:0], `MATCH_A_LIMIT_OFS}, `LIMIT_RESET);
      expect_reg({2'b00, c[1:0], `MATCH_B_LIMIT_OFS}, `LIMIT_RESET);
    end
    put(8'h80, 8'h5A);
    expect_reg(8'h80, 8'h00);
  endtask : t_reset_values
  task t_apart;
    put(8'h20, 8'h5A);
    put(8'h21, 8'h3C);
    put(8'h22, 8'hC3);
    expect_reg(8'h20, 8'h5A);
    expect_reg(8'h21, 8'h3C);
    expect_reg(8'h22, 8'hC3);
  endtask : t_apart
  task t_stop_start;
    logic [7:0] v1, v2;
    put(8'h10, 8'h00);
    put(8'h13, 8'h01);
    get(8'h10, v1);
    get(8'h10, v2);
    check(v2 - v1, 8'h02);
    put(8'h13, 8'h00);
    get(8'h10, v1);
    tick(5);
    expect_reg(8'h10, v1);
    put(8'h13, 8'h01);
    get(8'h10, v2);
    bit_is(v2 != v1, 1'b1);
    put(8'h13, 8'h00);
  endtask : t_stop_start
  task t_oneshot;
    logic [7:0] v;
    put(8'h02, 8'h10);
    put(8'h04, 8'h20);
    put(8'h06, 8'h02);
    put(`IRQ_ENABLE_ADDR, 8'h01);
    put(8'h03, 8'h13);
    tick(0);
    bit_is(pin[0], 1'b1);
    bit_is(oe[0], 1'b1);
    wait_req(0, 40, 1'b1);
    tick(2);
    bit_is(irq, 1'b1);
    bit_is(pin[0], 1'b0);
    expect_reg(8'h05, 8'h02);
    expect_reg(8'h03, 8'h12);
    get(8'h00, v);
    expect_reg(8'h00, v);
    put(8'h05, 8'h02);
    tick(2);
    bit_is(irq, 1'b0);
  endtask : t_oneshot
  task t_no_xfer;
    put(8'h32, 8'h08);
    put(8'h33, 8'h03);
    wait_req(3, 40, 1'b0);
    expect_reg(8'h35, 8'h02);
    put(8'h35, 8'h02);
    expect_reg(8'h35, 8'h00);
  endtask : t_no_xfer
  task t_shutdown;
    logic [7:0] v0, v1;
    put(`UNIT_CTRL_ADDR, 8'h04);
    put(8'h03, 8'h01);
    put(8'h13, 8'h01);
    get(8'h00, v0);
    get(8'h10, v1);
    tick(4);
    expect_reg(8'h00, v0);
    expect_reg(8'h10, v1);
    put(`UNIT_CTRL_ADDR, 8'h00);
    put(8'h03, 8'h00);
    put(8'h13, 8'h00);
  endtask : t_shutdown
  task t_actions;
    logic [7:0] v;
    int n;
    put(8'h10, 8'h00);
    put(8'h11, 8'h05);
    put(8'h14, 8'h02);
    put(8'h13, 8'h05);
    tick(8);
    bit_is(pin[1], 1'b1);
    get(8'h10, v);
    bit_is(v <= 8'h05, 1'b1);
    put(8'h14, 8'h01);
    tick(8);
    bit_is(pin[1], 1'b0);
    put(8'h14, 8'h03);
    changes(1, n);
    check(n[7:0], 8'h02);
    put(8'h14, 8'h00);
    changes(1, n);
    check(n[7:0], 8'h00);
    put(8'h13, 8'h00);
  endtask : t_actions
  task t_cascade;
    put(`UNIT_CTRL_ADDR, 8'h02);
    put(8'h20, 8'h00);
    put(8'h30, 8'hF0);
    put(8'h22, 8'h02);
    put(8'h32, 8'h20);
    put(8'h34, 8'h20);
    put(8'h23, 8'h03);
    put(8'h33, 8'h13);
    tick(8);
    bit_is(pin[2], 1'b1);
    bit_is(oe[2], 1'b1);
    bit_is(oe[3], 1'b0);
    wait_req(3, 400, 1'b1);
    expect_reg(8'h20, 8'h02);
    expect_reg(8'h35, 8'h02);
    tick(0);
    bit_is(pin[2], 1'b0);
  endtask : t_cascade

  initial begin
    repeat (10) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    t_reset_values();
    t_apart();
    t_stop_start();
    t_oneshot();
    t_no_xfer();
    t_shutdown();
    t_actions();
    t_cascade();
    final_report();
  end
endmodule : oneshot_timer_bench
